// File: rtl/lfs_consts.vh
`ifndef LFS_CONSTS_VH
`define LFS_CONSTS_VH
// register byte offsets
`define LFS_OFF_FLAGS 12'h000
`define LFS_OFF_STRING 12'h004
`define LFS_OFF_CTRL 12'h008
`define LFS_OFF_STATE 12'h00c
// sticky flag positions
`define LFS_B_LED_SUM 0
`define LFS_B_UNUSED 1
`define LFS_B_I2C_TO 2
`define LFS_B_VIN_UV 3
`define LFS_B_VIN_OV 4
`define LFS_B_VDD_LOW 5
`define LFS_B_VIN_OC 6
`define LFS_B_PUMP_LVL 7
`define LFS_B_PUMP_MISS 8
`define LFS_B_SYNC_LOST 9
`define LFS_B_CRC 10
`define LFS_B_OVP_LOW 11
`define LFS_B_OVP_HIGH 12
`define LFS_B_BST_OC 13
`define LFS_B_CH_RES 14
`define LFS_B_MODE_RES 15
`define LFS_B_FREQ_RES 16
`define LFS_NFLAGS 17
// flags that raise the interrupt (not ovp low nor the resistor flags)
`define LFS_IRQ_MASK 17'h037ff
// control register fields and reset value
`define LFS_B_CTRL_EN 0
`define LFS_B_CTRL_BRIGHT 1
`define LFS_RST_CTRL 2'h0
// fallback settings
`define LFS_DEF_CHANNELS 3'h6
`define LFS_DEF_ADDR 7'h2a
`define LFS_DEF_BOOST_KHZ 400
`define LFS_DEF_PWM_HZ 305
// timing
`define LFS_CLK_MHZ 100
`define LFS_T_GND_MS 20
`define LFS_T_PROBE_US 300
`define LFS_T_I2C_MS 500
`define LFS_T_RECOV_MS 100
`define LFS_T_BSTOC_MS 110
`define LFS_SYNC_MIN_KHZ 75
// cycles at 100 MHz: 20 ms, 300 us, 500 ms, 100 ms, 110 ms, 75 kHz period
`define LFS_N_GND 27'h1e8480
`define LFS_N_PROBE 27'h7530
`define LFS_N_I2C 27'h2faf080
`define LFS_N_RECOV 27'h989680
`define LFS_N_BSTOC 27'ha7d8c0
`define LFS_N_SYNC 11'h535
`endif

// File: rtl/lfs_supervisor.v
// Summary of operation
// R1 - used output below ground threshold 20 ms: channel off, 300 us test current
// R2 - still below headroom after the probe: ground short reported on that channel
// R3 - ground short: boost, outputs and power FET off, enter fault recovery
// R4 - ground short sets summary flag, interrupt, cause bit and channel bits
// R5 - cause and channel bits held until power loss; summary flag cleared by host
// R6 - unused outputs not grounded at init: flag, interrupt, keep running
// R7 - string configuration captured once at init, never re-evaluated
// R8 - bus transaction without stop for 500 ms: reset bus logic, flag, interrupt
// R9 - input undervoltage: flag, interrupt, standby, restart only once cleared
// R10 - input overvoltage: flag, interrupt, standby, restart only once cleared
// R11 - logic supply low: flag, interrupt, no recovery, resume when it returns
// R12 - input overcurrent or pump level fault: flag, interrupt, recovery, 100 ms
// R13 - pump parts missing: pump off, both pump flags, interrupt, keep running
// R14 - sync clock lost or below 75 kHz: flag, internal clock, spread by level
// R15 - trim load crc failure: flag, interrupt, keep running
// R16 - boost low overvoltage: flag without interrupt, halt switching only
// R17 - boost high overvoltage: flag, interrupt, recovery until voltage falls
// R18 - feedback under threshold 110 ms: boost overcurrent, interrupt, recovery
// R19 - channel resistor invalid: flag without interrupt, six channels default
// R20 - mode resistor invalid: flag without interrupt, phase shift, address 0x2a
// R21 - frequency resistor invalid: flag without interrupt, 400 kHz and 305 Hz
// R22 - recovery holds everything off 100 ms, restarts if enabled and bright (the code keeps pump_en on during recovery)
// R23 - interrupt output high while any interrupt flag stays set
//
// Register access over APB and the register offsets are this design's own decisions.
`timescale 1ns/1ps
`include "lfs_consts.vh"
`default_nettype none
module lfs_supervisor #(
    parameter NCH = 6,
    parameter [26:0] N_GND = `LFS_N_GND,
    parameter [26:0] N_PROBE = `LFS_N_PROBE,
    parameter [26:0] N_I2C = `LFS_N_I2C,
    parameter [26:0] N_RECOV = `LFS_N_RECOV,
    parameter [26:0] N_BSTOC = `LFS_N_BSTOC
) (
    input wire pclk,
    input wire presetn,
    input wire ce,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output wire pready,
    output wire pslverr,
    output reg [31:0] prdata,
    input wire vin_uv_in,
    input wire vin_ov_in,
    input wire vdd_low_in,
    input wire vin_oc_in,
    input wire pump_bad_in,
    input wire pump_missing_in,
    input wire ovp_low_in,
    input wire ovp_high_in,
    input wire fb_uv_in,
    input wire boost_sync_input,
    input wire [NCH-1:0] gnd_low_in,
    input wire [NCH-1:0] headroom_low_in,
    input wire init_done,
    input wire crc_fail,
    input wire [2:0] ledset_code,
    input wire ledset_bad,
    input wire [6:0] mode_addr,
    input wire mode_phase_shift,
    input wire mode_bad,
    input wire boost_fset_bad,
    input wire dimming_freq_resistor_bad,
    input wire [NCH-1:0] unused_not_gnd,
    input wire i2c_active,
    output reg i2c_reset,
    output wire irq,
    output reg boost_en,
    output reg boost_switch_en,
    output reg plfet_en,
    output reg pump_en,
    output reg [NCH-1:0] led_en,
    output reg [NCH-1:0] test_current_en,
    output reg use_internal_clk,
    output reg spread_spectrum_en,
    output reg [2:0] cfg_channels,
    output reg [6:0] cfg_addr,
    output reg cfg_phase_shift,
    output reg cfg_boost_default,
    output reg cfg_pwm_default
);
    localparam [1:0] ST_INIT = 2'h0;
    localparam [1:0] ST_STBY = 2'h1;
    localparam [1:0] ST_RUN = 2'h2;
    localparam [1:0] ST_RECOV = 2'h3;
    localparam NPIN = 10 + 2 * NCH;
    localparam [10:0] N_SYNC = `LFS_N_SYNC;

    // pin synchroniser: stage one is read only by stage two
    wire [NPIN-1:0] pin_raw = {headroom_low_in, gnd_low_in, boost_sync_input, fb_uv_in,
                               ovp_high_in, ovp_low_in, pump_missing_in, pump_bad_in,
                               vin_oc_in, vdd_low_in, vin_ov_in, vin_uv_in};
    reg [NPIN-1:0] pin_m_r;
    reg [NPIN-1:0] pin_s_r;
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_m_r <= {NPIN{1'b0}};
            pin_s_r <= {NPIN{1'b0}};
        end else if (ce) begin
            pin_m_r <= pin_raw;
            pin_s_r <= pin_m_r;
        end
    end
    wire vin_uv = pin_s_r[0];
    wire vin_ov = pin_s_r[1];
    wire vdd_low = pin_s_r[2];
    wire vin_oc = pin_s_r[3];
    wire pump_bad = pin_s_r[4];
    wire pump_miss = pin_s_r[5];
    wire ovp_low = pin_s_r[6];
    wire ovp_high = pin_s_r[7];
    wire fb_uv = pin_s_r[8];
    wire sync_s = pin_s_r[9];
    wire [NCH-1:0] gnd_low = pin_s_r[10 +: NCH];
    wire [NCH-1:0] hr_low = pin_s_r[10 + NCH +: NCH];

    reg [1:0] state_r;
    reg [1:0] state_nxt;
    reg [1:0] ctrl_r;
    reg [`LFS_NFLAGS-1:0] flags_r;
    reg [`LFS_NFLAGS-1:0] flag_set;
    reg gnd_cause_r;
    reg [NCH-1:0] ch_fault_r;
    reg [NCH-1:0] used_r;
    reg [26:0] recov_cnt_r;
    reg [26:0] bstoc_cnt_r;
    reg [26:0] i2c_cnt_r;
    reg [10:0] gap_cnt_r;
    reg sync_d_r;
    reg sync_seen_r;
    reg sync_lost_r;
    wire [NCH-1:0] gnd_hit;
    wire [NCH-1:0] probing;
    wire run = (state_r == ST_RUN);

    // per channel ground-short debounce then probe
    genvar g;
    generate
        for (g = 0; g < NCH; g = g + 1) begin : gch
            reg [26:0] low_cnt_r;
            reg [26:0] probe_cnt_r;
            reg probe_r;
            wire watch = run && used_r[g] && !vdd_low;
            always @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    low_cnt_r <= 27'h0;
                    probe_cnt_r <= 27'h0;
                    probe_r <= 1'b0;
                end else if (ce) begin
                    if (!watch) begin
                        low_cnt_r <= 27'h0;
                        probe_cnt_r <= 27'h0;
                        probe_r <= 1'b0;
                    end else if (probe_r) begin
                        if (probe_cnt_r == N_PROBE - 27'h1) begin
                            probe_r <= 1'b0;
                            probe_cnt_r <= 27'h0;
                            low_cnt_r <= 27'h0;
                        end else begin
                            probe_cnt_r <= probe_cnt_r + 27'h1;
                        end
                    end else if (!gnd_low[g]) begin
                        low_cnt_r <= 27'h0;
                    end else if (low_cnt_r == N_GND - 27'h1) begin
                        probe_r <= 1'b1; // [R1]
                    end else begin
                        low_cnt_r <= low_cnt_r + 27'h1;
                    end
                end
            end
            assign probing[g] = probe_r;
            // judged on the last probe cycle
            assign gnd_hit[g] = probe_r && watch && hr_low[g] &&
                                (probe_cnt_r == N_PROBE - 27'h1); // [R2]
        end
    endgenerate
    wire gnd_fault = |gnd_hit;

    // sync clock monitor; rising to rising is one full period
    wire sync_edge = sync_s && !sync_d_r;
    wire sync_gap = (gap_cnt_r == N_SYNC);
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync_d_r <= 1'b0;
            gap_cnt_r <= 11'h0;
            sync_seen_r <= 1'b0;
            sync_lost_r <= 1'b0;
        end else if (ce) begin
            sync_d_r <= sync_s;
            if (!ctrl_r[`LFS_B_CTRL_EN]) begin
                sync_seen_r <= 1'b0;
                sync_lost_r <= 1'b0;
                gap_cnt_r <= 11'h0;
            end else if (sync_edge) begin
                gap_cnt_r <= 11'h0;
                sync_seen_r <= 1'b1;
            end else if (!sync_gap) begin
                gap_cnt_r <= gap_cnt_r + 11'h1;
            end else if (sync_seen_r) begin
                sync_lost_r <= 1'b1; // [R14]
            end
        end
    end

    // fsm
    wire start_ok = ctrl_r[`LFS_B_CTRL_EN] && ctrl_r[`LFS_B_CTRL_BRIGHT] && !vin_uv && !vin_ov;
    wire bstoc_hit = run && fb_uv && (bstoc_cnt_r == N_BSTOC - 27'h1);
    wire recov_done = (recov_cnt_r == N_RECOV - 27'h1);
    always @* begin
        state_nxt = state_r;
        case (state_r)
            ST_INIT: begin
                if (init_done) begin
                    state_nxt = ST_STBY;
                end
            end
            ST_STBY: begin
                if (start_ok) begin
                    state_nxt = ST_RUN; // [R9] [R10]
                end
            end
            ST_RUN: begin
                if (vin_uv || vin_ov || !ctrl_r[`LFS_B_CTRL_EN]) begin
                    state_nxt = ST_STBY; // [R9] [R10]
                end else if (gnd_fault || vin_oc || pump_bad || ovp_high || bstoc_hit) begin
                    state_nxt = ST_RECOV; // [R3] [R12] [R17] [R18]
                end
            end
            default: begin
                // the wait outlasts a high overvoltage that persists
                if (recov_done && !ovp_high) begin
                    state_nxt = ST_STBY; // [R22] [R17]
                end
            end
        endcase
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r <= ST_INIT;
            recov_cnt_r <= 27'h0;
            bstoc_cnt_r <= 27'h0;
        end else if (ce) begin
            state_r <= state_nxt;
            if (state_r != ST_RECOV) begin
                recov_cnt_r <= 27'h0;
            end else if (!recov_done) begin
                recov_cnt_r <= recov_cnt_r + 27'h1; // [R12] [R22]
            end
            if (!run || !fb_uv || bstoc_hit) begin
                bstoc_cnt_r <= 27'h0;
            end else begin
                bstoc_cnt_r <= bstoc_cnt_r + 27'h1; // [R18]
            end
        end
    end

    // bus stall watchdog; held off after a bus reset until i2c_active drops
    reg i2c_hold_r;
    wire i2c_hit = i2c_active && !i2c_hold_r && (i2c_cnt_r == N_I2C - 27'h1);
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            i2c_cnt_r <= 27'h0;
            i2c_hold_r <= 1'b0;
            i2c_reset <= 1'b0;
        end else if (ce) begin
            i2c_reset <= i2c_hit; // [R8]
            if (!i2c_active) begin
                i2c_cnt_r <= 27'h0;
                i2c_hold_r <= 1'b0;
            end else if (i2c_hit) begin
                i2c_hold_r <= 1'b1;
                i2c_cnt_r <= 27'h0;
            end else if (!i2c_hold_r) begin
                i2c_cnt_r <= i2c_cnt_r + 27'h1;
            end
        end
    end

    // init capture, taken once on the init pulse
    wire init_take = (state_r == ST_INIT) && init_done;
    wire ledset_inv = ledset_bad || (ledset_code == 3'h0) || (ledset_code > 3'h6);
    wire [2:0] chans = ledset_inv ? `LFS_DEF_CHANNELS : ledset_code;
    wire [NCH-1:0] used_cap = ~({NCH{1'b1}} << chans);

    always @* begin
        flag_set = {`LFS_NFLAGS{1'b0}};
        flag_set[`LFS_B_LED_SUM] = gnd_fault; // [R4]
        flag_set[`LFS_B_UNUSED] = init_take && |(unused_not_gnd & ~used_cap); // [R6]
        flag_set[`LFS_B_I2C_TO] = i2c_hit; // [R8]
        flag_set[`LFS_B_VIN_UV] = vin_uv; // [R9]
        flag_set[`LFS_B_VIN_OV] = vin_ov; // [R10]
        flag_set[`LFS_B_VDD_LOW] = vdd_low; // [R11]
        flag_set[`LFS_B_VIN_OC] = vin_oc; // [R12]
        flag_set[`LFS_B_PUMP_LVL] = pump_bad || pump_miss; // [R12] [R13]
        flag_set[`LFS_B_PUMP_MISS] = pump_miss; // [R13]
        flag_set[`LFS_B_SYNC_LOST] = sync_lost_r; // [R14]
        flag_set[`LFS_B_CRC] = init_take && crc_fail; // [R15]
        flag_set[`LFS_B_OVP_LOW] = run && ovp_low; // [R16]
        flag_set[`LFS_B_OVP_HIGH] = run && ovp_high; // [R17]
        flag_set[`LFS_B_BST_OC] = bstoc_hit; // [R18]
        flag_set[`LFS_B_CH_RES] = init_take && ledset_inv; // [R19]
        flag_set[`LFS_B_MODE_RES] = init_take && mode_bad; // [R20]
        flag_set[`LFS_B_FREQ_RES] = init_take && (boost_fset_bad || dimming_freq_resistor_bad); // [R21]
    end

    // apb: zero wait states, read data registered in the setup cycle
    wire map_flags = (paddr == `LFS_OFF_FLAGS);
    wire map_string = (paddr == `LFS_OFF_STRING);
    wire map_ctrl = (paddr == `LFS_OFF_CTRL);
    wire map_state = (paddr == `LFS_OFF_STATE);
    wire mapped = map_flags || map_string || map_ctrl || map_state;
    wire wr = psel && penable && pwrite;
    assign pready = 1'b1;
    assign pslverr = psel && penable && !mapped;
    wire [`LFS_NFLAGS-1:0] w1c = (wr && map_flags) ? pwdata[`LFS_NFLAGS-1:0] :
                                 {`LFS_NFLAGS{1'b0}};

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flags_r <= {`LFS_NFLAGS{1'b0}};
            ctrl_r <= `LFS_RST_CTRL;
            gnd_cause_r <= 1'b0;
            ch_fault_r <= {NCH{1'b0}};
            prdata <= 32'h0;
        end else if (ce) begin
            flags_r <= (flags_r & ~w1c) | flag_set; // [R5]
            if (gnd_fault) begin
                gnd_cause_r <= 1'b1; // [R4] [R5]
                ch_fault_r <= ch_fault_r | gnd_hit;
            end
            if (wr && map_ctrl) begin
                ctrl_r <= pwdata[1:0];
            end
            if (psel && !penable) begin
                if (map_flags) begin
                    prdata <= {{(32 - `LFS_NFLAGS){1'b0}}, flags_r};
                end else if (map_string) begin
                    prdata <= {{(31 - NCH){1'b0}}, ch_fault_r, gnd_cause_r};
                end else if (map_ctrl) begin
                    prdata <= {30'h0, ctrl_r};
                end else if (map_state) begin
                    prdata <= {16'h0, cfg_boost_default, cfg_pwm_default, cfg_phase_shift,
                               cfg_addr, cfg_channels, use_internal_clk, state_r};
                end else begin
                    prdata <= 32'h0;
                end
            end
        end
    end

    assign irq = |(flags_r & `LFS_IRQ_MASK); // [R23]

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            used_r <= {NCH{1'b0}};
            cfg_channels <= `LFS_DEF_CHANNELS;
            cfg_addr <= `LFS_DEF_ADDR;
            cfg_phase_shift <= 1'b1;
            cfg_boost_default <= 1'b1;
            cfg_pwm_default <= 1'b1;
        end else if (ce && init_take) begin
            used_r <= used_cap; // [R7]
            cfg_channels <= chans; // [R19]
            cfg_addr <= mode_bad ? `LFS_DEF_ADDR : mode_addr; // [R20]
            cfg_phase_shift <= mode_bad ? 1'b1 : mode_phase_shift;
            cfg_boost_default <= boost_fset_bad; // [R21]
            cfg_pwm_default <= dimming_freq_resistor_bad;
        end
    end

    // power outputs; supply-low gates boost, FET and channel outputs, not the pump, without leaving the state
    wire on = run && !vdd_low && state_nxt == ST_RUN;
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            boost_en <= 1'b0;
            boost_switch_en <= 1'b0;
            plfet_en <= 1'b0;
            pump_en <= 1'b0;
            led_en <= {NCH{1'b0}};
            test_current_en <= {NCH{1'b0}};
            use_internal_clk <= 1'b1;
            spread_spectrum_en <= 1'b0;
        end else if (ce) begin
            boost_en <= on; // [R3] [R11] [R22]
            boost_switch_en <= on && !ovp_low; // [R16]
            plfet_en <= on;
            pump_en <= (state_r != ST_INIT) && !pump_miss; // [R13]
            led_en <= on ? (used_r & ~probing & ~ch_fault_r) : {NCH{1'b0}}; // [R1]
            test_current_en <= on ? probing : {NCH{1'b0}};
            use_internal_clk <= !sync_seen_r || sync_lost_r; // [R14]
            spread_spectrum_en <= sync_lost_r && sync_s;
        end
    end
endmodule // lfs_supervisor
`default_nettype wire

// File: sim/lfs_checker.sv
`timescale 1ns/1ps
`include "lfs_consts.vh"
`default_nettype none
module lfs_checker #(
    parameter NCH = 6
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic [11:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic irq,
    input wire logic i2c_active,
    input wire logic i2c_reset,
    input wire logic ovp_low_in,
    input wire logic boost_switch_en,
    input wire logic vdd_low_in,
    input wire logic boost_en,
    input wire logic plfet_en,
    input wire logic pump_missing_in,
    input wire logic pump_en,
    input wire logic init_done,
    input wire logic [2:0] cfg_channels,
    input wire logic [6:0] cfg_addr,
    input wire logic [NCH-1:0] led_en,
    input wire logic [NCH-1:0] test_current_en
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    // irq of the setup cycle belongs to the flags latched into prdata
    a_irq_flags:
        assert property (psel && penable && $past(psel) && !$past(penable)
            && $past(paddr) == 12'h000 |-> $past(irq) == |(prdata[16:0] & `LFS_IRQ_MASK))
            else $error("irq disagrees with flags");
    a_i2c_pulse:
        assert property (i2c_reset |=> !i2c_reset) else $error("bus reset too long");
    a_i2c_cause:
        assert property (i2c_reset |-> $past(i2c_active) ##[0:1] irq)
            else $error("bus reset without cause or irq");
    a_ovpl_halt:
        assert property (ovp_low_in [*4] |=> !boost_switch_en) else $error("boost still switching");
    a_probe_excl:
        assert property ((led_en & test_current_en) == '0) else $error("probe on a driven channel");
    a_probe_hold:
        assert property ($rose(test_current_en[0]) |-> test_current_en[0] [*8])
            else $error("probe too short");
    a_vdd_gate:
        assert property (vdd_low_in [*4] |=> !boost_en && !plfet_en && led_en == '0)
            else $error("outputs on with logic supply low");
    a_pump_off:
        assert property (pump_missing_in [*4] |=> !pump_en) else $error("pump still on");
    logic init_seen_r;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) init_seen_r <= 1'b0;
        else if (init_done) init_seen_r <= 1'b1;
    end
    a_cfg_frozen:
        assert property ($past(init_seen_r) |-> $stable(cfg_channels) && $stable(cfg_addr))
            else $error("configuration changed after capture");
    c_probe: cover property ($rose(test_current_en[0]));
    c_i2c: cover property (i2c_reset);
    c_halt: cover property ($fell(boost_switch_en));
endmodule // lfs_checker
bind lfs_supervisor lfs_checker #(.NCH(NCH)) i_chk (.*);
`default_nettype wire

// File: sim/lfs_host.sv
`timescale 1ns/1ps
`default_nettype none
module lfs_host (
    input wire logic pclk,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [31:0] prdata,
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [11:0] paddr,
    output logic [31:0] pwdata
);
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
    end
    // request held until pready is seen at a rising edge
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
        output logic [31:0] q, output logic err);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        q = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
endmodule // lfs_host
`default_nettype wire

// File: sim/lfs_supervisor_test.sv
`timescale 1ns/1ps
`include "lfs_consts.vh"
`default_nettype none
module lfs_supervisor_test;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic ce = 1'b1;
    logic psel, penable, pwrite, pready, pslverr, irq, i2c_reset, boost_en, boost_switch_en;
    logic plfet_en, pump_en, use_internal_clk, spread_spectrum_en;
    logic cfg_phase_shift, cfg_boost_default, cfg_pwm_default;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [8:0] flt = 9'h000;
    logic boost_sync_input = 1'b0, i2c_active = 1'b0, init_done = 1'b0, crc_fail = 1'b0;
    logic ledset_bad = 1'b0, mode_phase_shift = 1'b0, mode_bad = 1'b0;
    logic boost_fset_bad = 1'b0, dimming_freq_resistor_bad = 1'b0;
    logic [2:0] ledset_code = 3'h1;
    logic [6:0] mode_addr = 7'h00;
    logic [5:0] gnd_low_in = 6'h00, headroom_low_in = 6'h00, unused_not_gnd = 6'h00;
    logic [5:0] led_en, test_current_en;
    logic [2:0] cfg_channels;
    logic [6:0] cfg_addr;
    logic [15:0] lfsr = 16'h79ad;
    logic [31:0] expq[$];
    int n_mismatch = 0, num_checks = 0, cyc = 0;
    int fi[10] = '{0, 1, 2, 3, 4, 5, 6, 7, 8, 8};
    int fh[10] = '{6, 6, 6, 6, 6, 6, 6, 6, 20, 45};
    logic [16:0] ff[10] = '{17'h8, 17'h10, 17'h20, 17'h40, 17'h80, 17'h180, 17'h800, 17'h1000,
        17'h0, 17'h2000};
    logic fb[10] = '{0, 0, 0, 0, 0, 1, 1, 0, 1, 0};
    logic fr[10] = '{0, 0, 0, 1, 1, 0, 0, 1, 0, 1};

    lfs_supervisor #(.N_GND(27'h28), .N_PROBE(27'ha), .N_I2C(27'h32), .N_RECOV(27'h1e),
        .N_BSTOC(27'h23)) i_dut (.*, .vin_uv_in(flt[0]), .vin_ov_in(flt[1]),
        .vdd_low_in(flt[2]), .vin_oc_in(flt[3]), .pump_bad_in(flt[4]),
        .pump_missing_in(flt[5]), .ovp_low_in(flt[6]), .ovp_high_in(flt[7]), .fb_uv_in(flt[8]));
    lfs_host i_host (.*);

    always #5 pclk = ~pclk;

    function automatic logic [15:0] nxt(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction

    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic final_report;
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] q;
        logic e;
        i_host.xfer(1'b1, a, d, q, e);
    endtask

    task automatic rd(input logic [11:0] a, input logic [31:0] exp, output logic e);
        logic [31:0] q;
        expq.push_back(exp);
        i_host.xfer(1'b0, a, 32'h0, q, e);
    endtask

    task automatic wait_boost(input logic v, output int c);
        c = 0;
        do begin
            @(negedge pclk);
            c++;
        end while (boost_en !== v && c < 300);
    endtask

    // read results are judged here, against the oldest note
    always @(posedge pclk) begin
        if (psel && penable && pready && !pwrite && expq.size() > 0) begin
            cmp(prdata, expq.pop_front());
        end
    end

    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_mismatch++;
            final_report();
        end
    end

    initial begin
        int c;
        logic [2:0] n;
        logic e;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        lfsr = nxt(lfsr);
        n = 3'(lfsr % 5 + 1);
        @(posedge pclk);
        ledset_code <= n;
        mode_addr <= lfsr[6:0];
        mode_bad <= 1'b1;
        boost_fset_bad <= 1'b1;
        crc_fail <= 1'b1;
        unused_not_gnd <= 6'h20;
        init_done <= 1'b1;
        @(posedge pclk);
        init_done <= 1'b0;
        @(negedge pclk);
        cmp(cfg_channels, n);
        cmp(cfg_addr, 7'h2a);
        cmp(cfg_phase_shift, 1'b1);
        cmp(cfg_boost_default, 1'b1);
        cmp(cfg_pwm_default, 1'b0);
        rd(12'h000, 32'h18402, e);
        cmp(irq, 1'b1);
        wr(12'h000, 32'h1ffff);
        rd(12'h000, 32'h0, e);
        @(negedge pclk);
        cmp(irq, 1'b0);
        lfsr = nxt(lfsr);
        wr(12'h008, {16'h0, lfsr});
        rd(12'h008, {30'h0, lfsr[1:0]}, e);
        rd(12'h010, 32'h0, e);
        cmp(e, 1'b1);
        wr(12'h004, 32'hffff);
        rd(12'h004, 32'h0, e);
        rd(12'h00c, {16'h0, 3'h5, `LFS_DEF_ADDR, n, 3'h5}, e);
        wr(12'h008, 32'h3);
        wait_boost(1'b1, c);
        $display("init and register test done");
        @(posedge pclk);
        gnd_low_in <= 6'h01;
        headroom_low_in <= 6'h01;
        c = 0;
        while (test_current_en[0] !== 1'b1 && c < 100) begin
            @(negedge pclk);
            c++;
        end
        cmp(c >= 40 && c < 46, 1'b1);
        cmp(led_en[0], 1'b0);
        wait_boost(1'b0, c);
        cmp(c >= 9 && c < 16, 1'b1);
        cmp({plfet_en, led_en}, 7'h0);
        rd(12'h000, 32'h1, e);
        rd(12'h004, 32'h3, e);
        gnd_low_in <= 6'h00;
        headroom_low_in <= 6'h00;
        wr(12'h008, 32'h1);
        repeat (60) @(negedge pclk);
        cmp(boost_en, 1'b0);
        wr(12'h000, 32'h1ffff);
        rd(12'h000, 32'h0, e);
        rd(12'h004, 32'h3, e);
        wr(12'h008, 32'h3);
        wait_boost(1'b1, c);
        cmp(boost_en, 1'b1);
        $display("ground short test done");
        for (int k = 0; k < 10; k++) begin
            wr(12'h000, 32'h1ffff);
            flt[fi[k]] <= 1'b1;
            repeat (fh[k]) @(negedge pclk);
            cmp(boost_en, fb[k]);
            if (k == 5) cmp(pump_en, 1'b0);
            if (k == 6) cmp(boost_switch_en, 1'b0);
            @(posedge pclk);
            flt[fi[k]] <= 1'b0;
            wait_boost(1'b1, c);
            cmp(c >= 15, fr[k]);
            rd(12'h000, ff[k], e);
            @(negedge pclk);
            cmp(irq, |(ff[k] & `LFS_IRQ_MASK));
        end
        $display("supply and boost fault test done");
        wr(12'h000, 32'h1ffff);
        i2c_active <= 1'b1;
        c = 0;
        while (i2c_reset !== 1'b1 && c < 100) begin
            @(negedge pclk);
            c++;
        end
        cmp(c >= 48 && c < 54, 1'b1);
        c = 0;
        repeat (60) begin
            @(negedge pclk);
            c += i2c_reset;
        end
        cmp(c, 0);
        @(posedge pclk);
        i2c_active <= 1'b0;
        rd(12'h000, 32'h4, e);
        wr(12'h000, 32'h1ffff);
        repeat (5) begin
            @(posedge pclk);
            boost_sync_input <= ~boost_sync_input;
            repeat (6) @(posedge pclk);
        end
        cmp(use_internal_clk, 1'b0);
        repeat (1400) @(negedge pclk);
        cmp(use_internal_clk, 1'b1);
        cmp(spread_spectrum_en, 1'b1);
        rd(12'h000, 32'h200, e);
        $display("bus timeout and sync test done");
        ce <= 1'b0;
        flt[0] <= 1'b1;
        repeat (8) @(posedge pclk);
        ce <= 1'b1;
        flt[0] <= 1'b0;
        rd(12'h000, 32'h200, e);
        ledset_code <= n + 3'h1;
        init_done <= 1'b1;
        @(posedge pclk);
        init_done <= 1'b0;
        repeat (3) @(negedge pclk);
        cmp(cfg_channels, n);
        $display("capture test done");
        final_report();
    end
endmodule // lfs_supervisor_test
`default_nettype wire
